/* File: hw/srx_pkg.sv */
package srx_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_LOOP_CTRL   = 12'h811;
  localparam logic [11:0] ADDR_STAT_ROUTE  = 12'h812;
  localparam logic [11:0] ADDR_MODE_RATE   = 12'h835;
  localparam logic [11:0] ADDR_INPUT_CFG   = 12'h84d;
  localparam logic [11:0] ADDR_LOS_CFG     = 12'h86f;
  localparam logic [11:0] ADDR_CLK_DELAY   = 12'h870;
  localparam logic [11:0] ADDR_CLK_INVERT  = 12'h871;
  localparam logic [11:0] ADDR_WIDTH_SRC   = 12'h877;
  localparam logic [11:0] ADDR_LOCK_STATUS = 12'h880;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_BYPASS     = 0;
  localparam int BIT_LOOP_EN    = 1;
  localparam int BIT_SD         = 0;
  localparam int BIT_TRIPLE     = 1;
  localparam int BIT_AUTO       = 2;
  localparam int BIT_TRANSPORT  = 3;
  localparam int BIT_PROC_N     = 4;
  localparam int BIT_DESER_SEL  = 2;
  localparam int BIT_LOOP_SEL   = 3;
  localparam int BIT_LOSS_IN    = 8;
  localparam int BIT_SRC_REG    = 0;
  localparam int BIT_REG_WIDE   = 1;
  localparam int BIT_DDR        = 2;
  localparam int DLY_3G_LO      = 0;
  localparam int DLY_HD_LO      = 5;
  localparam int DLY_SD_LO      = 10;
  localparam int INV_3G         = 0;
  localparam int INV_HD         = 1;
  localparam int INV_SD         = 2;
  // ---------------------------------------------------------------
  // reset values and status pin count
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_LOOP_CTRL  = 16'h0002;
  localparam logic [15:0] RST_STAT_ROUTE = 16'h0003;
  localparam logic [15:0] RST_MODE_RATE  = 16'h0014;
  localparam logic [15:0] RST_INPUT_CFG  = 16'h0000;
  localparam logic [15:0] RST_LOS_CFG    = 16'h0000;
  localparam logic [15:0] RST_CLK_DELAY  = 16'h0000;
  localparam logic [15:0] RST_CLK_INVERT = 16'h0000;
  localparam logic [15:0] RST_WIDTH_SRC  = 16'h0000;
  localparam logic [2:0]  STAT_PINS      = 3'h6;
  // ---------------------------------------------------------------
  // line rates and output clock rates
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRX_RATE_SD = 3'b001,
    SRX_RATE_HD = 3'b010,
    SRX_RATE_3G = 3'b100
  } srx_rate_e;
  typedef enum logic [3:0] {
    SRX_CLK_148M5 = 4'b0001,
    SRX_CLK_74M25 = 4'b0010,
    SRX_CLK_27M   = 4'b0100,
    SRX_CLK_13M5  = 4'b1000
  } srx_clk_e;
endpackage : srx_pkg

/* File: hw/srx_output_lock.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - input field bits 3:2 pick the deserializer input and the loop input
// - one bit picks which serial input the signal-loss sensing watches
// - only the deserialized input can be retimed; the other loops raw
// - loop enable 0 disables loop; else bypass picks raw or retimed
// - loop source chosen independently of the deserializer input
// - three line rates, from detection or from manual rate bits
// - standard-definition bit set makes the triple-rate bit ignored
// - lock follows per-mode condition: video, transport stream, or pll
// - lock on status pin 3 after reset, movable to any of six pins
// - power-down with retimer active holds the previous lock value
// - 20-bit bus, 10 or 20 bit use, changes with the output clock
// - video mode width from the pin, or register when selector set
// - 20-bit video: luma or stream one high, chroma or stream two low
// - 10-bit video: words on upper ten, lower low; 3G always ddr
// - transport byte on bits 17:10, lsb on bit 10, lower ten low
// - transport: bit 19 code error flag, bit 18 sync character flag
// - sync flag high exactly on comma sync character words
// - code error flag high on disparity error or illegal code word
// - data-through passes raw words; width and ddr from registers/pin
// - output clock rate per width, rate and ddr, optional 1.001 divide
// - per-rate 5-bit output clock delay plus per-rate invert
// - manual rate: bit 0 standard definition, bit 1 3G versus HD
module srx_output_lock
  import srx_pkg::*;
(
  // clock and reset
  input  wire  logic        clk_sys,
  input  wire  logic        reset_n,
  // host register port
  input  wire  logic [11:0] csr_addr,
  input  wire  logic [15:0] csr_wdata,
  input  wire  logic        csr_wr,
  output logic [15:0]       csr_rdata,
  // device pins
  input  wire  logic        bus_width_select,
  input  wire  logic        power_down,
  // front end status
  input  wire  logic [1:0]  detected_rate,
  input  wire  logic        detected_frac,
  input  wire  logic        pll_locked,
  input  wire  logic        video_valid,
  input  wire  logic        stream_valid,
  // deserialized words
  input  wire  logic        word_valid,
  input  wire  logic [19:0] raw_word,
  input  wire  logic [7:0]  transport_byte,
  input  wire  logic        comma_seen,
  input  wire  logic        disparity_err,
  input  wire  logic        illegal_code,
  // serial routing
  output logic              deser_input_sel,
  output logic              loop_input_sel,
  output logic              signal_loss_input_choice,
  output logic              serial_loop_output_en,
  output logic              serial_loop_output_retimed,
  // retimer rate
  output logic [2:0]        line_rate,
  // status pins
  output logic [5:0]        status_pins,
  // parallel output
  output logic [19:0]       dout,
  output logic              dout_strobe,
  output logic              double_edge_active,
  output logic [3:0]        output_clock_rate,
  output logic              output_clock_frac,
  output logic [4:0]        output_clock_delay,
  output logic              output_clock_invert
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] rate_of(input logic sd, input logic tg);
    if (sd) begin
      rate_of = SRX_RATE_SD;
    end else if (tg) begin
      rate_of = SRX_RATE_3G;
    end else begin
      rate_of = SRX_RATE_HD;
    end
  endfunction : rate_of

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] width_pin_r;
  logic [1:0] width_pin_nxt;
  logic [1:0] pd_pin_r;
  logic [1:0] pd_pin_nxt;
  always_comb begin
    width_pin_nxt = {width_pin_r[0], bus_width_select};
    pd_pin_nxt    = {pd_pin_r[0], power_down};
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      width_pin_r <= 2'h0;
      pd_pin_r    <= 2'h0;
    end else begin
      width_pin_r <= width_pin_nxt;
      pd_pin_r    <= pd_pin_nxt;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] loop_ctrl_r;
  logic [15:0] loop_ctrl_nxt;
  logic [15:0] stat_route_r;
  logic [15:0] stat_route_nxt;
  logic [15:0] mode_rate_r;
  logic [15:0] mode_rate_nxt;
  logic [15:0] input_cfg_r;
  logic [15:0] input_cfg_nxt;
  logic [15:0] los_cfg_r;
  logic [15:0] los_cfg_nxt;
  logic [15:0] clk_delay_r;
  logic [15:0] clk_delay_nxt;
  logic [15:0] clk_invert_r;
  logic [15:0] clk_invert_nxt;
  logic [15:0] width_src_r;
  logic [15:0] width_src_nxt;
  always_comb begin
    loop_ctrl_nxt  = loop_ctrl_r;
    stat_route_nxt = stat_route_r;
    mode_rate_nxt  = mode_rate_r;
    input_cfg_nxt  = input_cfg_r;
    los_cfg_nxt    = los_cfg_r;
    clk_delay_nxt  = clk_delay_r;
    clk_invert_nxt = clk_invert_r;
    width_src_nxt  = width_src_r;
    if (csr_wr) begin
      unique case (csr_addr)
        ADDR_LOOP_CTRL:  loop_ctrl_nxt  = csr_wdata;
        ADDR_STAT_ROUTE: begin
          if (csr_wdata[2:0] < STAT_PINS) begin
            stat_route_nxt = csr_wdata;
          end
        end
        ADDR_MODE_RATE:  mode_rate_nxt  = csr_wdata;
        ADDR_INPUT_CFG:  input_cfg_nxt  = csr_wdata;
        ADDR_LOS_CFG:    los_cfg_nxt    = csr_wdata;
        ADDR_CLK_DELAY:  clk_delay_nxt  = csr_wdata;
        ADDR_CLK_INVERT: clk_invert_nxt = csr_wdata;
        ADDR_WIDTH_SRC:  width_src_nxt  = csr_wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      loop_ctrl_r  <= RST_LOOP_CTRL;
      stat_route_r <= RST_STAT_ROUTE;
      mode_rate_r  <= RST_MODE_RATE;
      input_cfg_r  <= RST_INPUT_CFG;
      los_cfg_r    <= RST_LOS_CFG;
      clk_delay_r  <= RST_CLK_DELAY;
      clk_invert_r <= RST_CLK_INVERT;
      width_src_r  <= RST_WIDTH_SRC;
    end else begin
      loop_ctrl_r  <= loop_ctrl_nxt;
      stat_route_r <= stat_route_nxt;
      mode_rate_r  <= mode_rate_nxt;
      input_cfg_r  <= input_cfg_nxt;
      los_cfg_r    <= los_cfg_nxt;
      clk_delay_r  <= clk_delay_nxt;
      clk_invert_r <= clk_invert_nxt;
      width_src_r  <= width_src_nxt;
    end
  end

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  logic retimer_bypass;
  logic video_processing_bypass_n;
  logic transport_stream_select;
  logic pin_or_register_source;
  logic double_edge_clock_select;
  logic wide_mode;
  logic in_video;
  logic in_transport;
  logic [2:0] rate;
  logic lock_cond;
  always_comb begin
    retimer_bypass            = loop_ctrl_r[BIT_BYPASS];
    video_processing_bypass_n = mode_rate_r[BIT_PROC_N];
    transport_stream_select   = mode_rate_r[BIT_TRANSPORT];
    pin_or_register_source    = width_src_r[BIT_SRC_REG];
    double_edge_clock_select  = width_src_r[BIT_DDR];
    in_video     = video_processing_bypass_n;
    in_transport = !video_processing_bypass_n && transport_stream_select;
    wide_mode = pin_or_register_source ? width_src_r[BIT_REG_WIDE]
                                       : width_pin_r[1];
    if (mode_rate_r[BIT_AUTO]) begin
      rate = rate_of(detected_rate[0], detected_rate[1]);
    end else begin
      rate = rate_of(mode_rate_r[BIT_SD], mode_rate_r[BIT_TRIPLE]);
    end
    if (in_video) begin
      lock_cond = pll_locked && video_valid;
    end else if (in_transport) begin
      lock_cond = pll_locked && stream_valid;
    end else begin
      lock_cond = pll_locked;
    end
  end

  // ---------------------------------------------------------------
  // lock and status pins
  // ---------------------------------------------------------------
  logic       lock_r;
  logic       lock_nxt;
  logic [5:0] stat_r;
  logic [5:0] stat_nxt;
  always_comb begin
    lock_nxt = lock_cond;
    if (pd_pin_r[1] && !retimer_bypass) begin
      lock_nxt = lock_r;
    end
    stat_nxt = 6'h00;
    stat_nxt[stat_route_r[2:0]] = lock_r;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lock_r <= 1'b0;
      stat_r <= 6'h00;
    end else begin
      lock_r <= lock_nxt;
      stat_r <= stat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // parallel output
  // ---------------------------------------------------------------
  logic [19:0] dout_r;
  logic [19:0] dout_nxt;
  logic        strobe_r;
  logic        strobe_nxt;
  logic        ddr_r;
  logic        ddr_nxt;
  logic [3:0]  clk_rate_r;
  logic [3:0]  clk_rate_nxt;
  always_comb begin
    dout_nxt   = dout_r;
    strobe_nxt = word_valid;
    if (word_valid) begin
      if (in_transport) begin
        dout_nxt = {disparity_err || illegal_code, comma_seen,
                    transport_byte, 10'h000};
      end else if (wide_mode) begin
        dout_nxt = raw_word;
      end else begin
        dout_nxt = {raw_word[9:0], 10'h000};
      end
    end
    ddr_nxt = !wide_mode && (double_edge_clock_select ||
                             (rate == SRX_RATE_3G));
    unique case (rate)
      SRX_RATE_3G: clk_rate_nxt = SRX_CLK_148M5;
      SRX_RATE_HD: clk_rate_nxt = (wide_mode || ddr_nxt) ? SRX_CLK_74M25
                                                         : SRX_CLK_148M5;
      default:     clk_rate_nxt = (wide_mode || ddr_nxt) ? SRX_CLK_13M5
                                                         : SRX_CLK_27M;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dout_r     <= 20'h00000;
      strobe_r   <= 1'b0;
      ddr_r      <= 1'b0;
      clk_rate_r <= SRX_CLK_27M;
    end else begin
      dout_r     <= dout_nxt;
      strobe_r   <= strobe_nxt;
      ddr_r      <= ddr_nxt;
      clk_rate_r <= clk_rate_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    deser_input_sel          = input_cfg_r[BIT_DESER_SEL];
    loop_input_sel           = input_cfg_r[BIT_LOOP_SEL];
    signal_loss_input_choice = los_cfg_r[BIT_LOSS_IN];
    serial_loop_output_en    = loop_ctrl_r[BIT_LOOP_EN];
    serial_loop_output_retimed = loop_ctrl_r[BIT_LOOP_EN] &&
                                 !retimer_bypass &&
                                 (loop_input_sel == deser_input_sel);
    line_rate           = rate;
    status_pins         = stat_r;
    dout                = dout_r;
    dout_strobe         = strobe_r;
    double_edge_active  = ddr_r;
    output_clock_rate   = clk_rate_r;
    output_clock_frac   = detected_frac && (rate != SRX_RATE_SD);
    unique case (rate)
      SRX_RATE_3G: begin
        output_clock_delay  = clk_delay_r[DLY_3G_LO +: 5];
        output_clock_invert = clk_invert_r[INV_3G];
      end
      SRX_RATE_HD: begin
        output_clock_delay  = clk_delay_r[DLY_HD_LO +: 5];
        output_clock_invert = clk_invert_r[INV_HD];
      end
      default: begin
        output_clock_delay  = clk_delay_r[DLY_SD_LO +: 5];
        output_clock_invert = clk_invert_r[INV_SD];
      end
    endcase
    unique case (csr_addr)
      ADDR_LOOP_CTRL:   csr_rdata = loop_ctrl_r;
      ADDR_STAT_ROUTE:  csr_rdata = stat_route_r;
      ADDR_MODE_RATE:   csr_rdata = mode_rate_r;
      ADDR_INPUT_CFG:   csr_rdata = input_cfg_r;
      ADDR_LOS_CFG:     csr_rdata = los_cfg_r;
      ADDR_CLK_DELAY:   csr_rdata = clk_delay_r;
      ADDR_CLK_INVERT:  csr_rdata = clk_invert_r;
      ADDR_WIDTH_SRC:   csr_rdata = width_src_r;
      ADDR_LOCK_STATUS: csr_rdata = {9'h000, rate, ddr_r, lock_r,
                                     pd_pin_r[1], wide_mode};
      default:          csr_rdata = 16'h0000;
    endcase
  end
endmodule : srx_output_lock
`default_nettype wire

/* File: tb/srx_output_lock_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// checker on the top ports
// ----------------------------------------
module srx_output_lock_props
  import srx_pkg::*;
(
  // clock, reset, register port
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [11:0] csr_addr,
  input wire logic [15:0] csr_wdata,
  input wire logic        csr_wr,
  // word input
  input wire logic        word_valid,
  // observed outputs
  input wire logic        deser_input_sel,
  input wire logic        loop_input_sel,
  input wire logic        signal_loss_input_choice,
  input wire logic        serial_loop_output_en,
  input wire logic        serial_loop_output_retimed,
  input wire logic [2:0]  line_rate,
  input wire logic [5:0]  status_pins,
  input wire logic [19:0] dout,
  input wire logic        dout_strobe,
  input wire logic [3:0]  output_clock_rate
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_in_sel;
    csr_wr && csr_addr == ADDR_INPUT_CFG |=>
      deser_input_sel == $past(csr_wdata[BIT_DESER_SEL]) &&
      loop_input_sel == $past(csr_wdata[BIT_LOOP_SEL]);
  endproperty
  a_in_sel: assert property (p_in_sel) else $error("routing");
  property p_los;
    csr_wr && csr_addr == ADDR_LOS_CFG |=>
      signal_loss_input_choice == $past(csr_wdata[BIT_LOSS_IN]);
  endproperty
  a_los: assert property (p_los) else $error("loss input");
  property p_loop_en;
    csr_wr && csr_addr == ADDR_LOOP_CTRL |=>
      serial_loop_output_en == $past(csr_wdata[BIT_LOOP_EN]);
  endproperty
  a_loop_en: assert property (p_loop_en) else $error("loop on");
  property p_retimed;
    serial_loop_output_retimed |->
      serial_loop_output_en && deser_input_sel == loop_input_sel;
  endproperty
  a_retimed: assert property (p_retimed) else $error("retimed");
  property p_rate;
    csr_wr && csr_addr == ADDR_MODE_RATE && !csr_wdata[BIT_AUTO] &&
      csr_wdata[BIT_SD] |=> line_rate == SRX_RATE_SD;
  endproperty
  a_rate: assert property (p_rate) else $error("line rate");
  property p_clk;
    $onehot(output_clock_rate);
  endproperty
  a_clk: assert property (p_clk) else $error("clock rate");
  property p_stat;
    $onehot0(status_pins);
  endproperty
  a_stat: assert property (p_stat) else $error("status pins");
  property p_strobe;
    word_valid |=> dout_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe");
  property p_hold;
    !word_valid |=> !dout_strobe && $stable(dout);
  endproperty
  a_hold: assert property (p_hold) else $error("bus hold");
  c_ret: cover property (serial_loop_output_retimed);
  c_lock: cover property (status_pins[3]);
  c_b2b: cover property (word_valid ##1 word_valid);
endmodule : srx_output_lock_props
bind srx_output_lock srx_output_lock_props i_props (
  .clk_sys, .reset_n, .csr_addr, .csr_wdata, .csr_wr, .word_valid,
  .deser_input_sel, .loop_input_sel, .signal_loss_input_choice,
  .serial_loop_output_en, .serial_loop_output_retimed, .line_rate,
  .status_pins, .dout, .dout_strobe, .output_clock_rate
);
`default_nettype wire

/* File: tb/srx_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// downstream logic sampling the bus
// ----------------------------------------
module srx_sink (
  // bus
  input  wire logic        clk_sys,
  input  wire logic [19:0] dout,
  input  wire logic        dout_strobe,
  // captured word
  output var  logic [19:0] last_word
);
  always_ff @(posedge clk_sys) begin
    if (dout_strobe) begin
      last_word <= dout;
    end
  end
endmodule : srx_sink
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// testbench
// ----------------------------------------
module tb_top;
  import srx_pkg::*;
  logic        clk_sys, reset_n, csr_wr, bus_width_select, power_down;
  logic        detected_frac, pll_locked, video_valid, stream_valid;
  logic        word_valid, comma_seen, disparity_err, illegal_code;
  logic [11:0] csr_addr;
  logic [15:0] csr_wdata, csr_rdata, dly, inv, v;
  logic [1:0]  detected_rate;
  logic [19:0] raw_word, dout, last_word, ex, ep;
  logic [7:0]  transport_byte;
  logic        dsel, lsel, lch, len, lret, dea, oinv;
  logic [2:0]  line_rate;
  logic [5:0]  status_pins;
  logic        strb, ofrac;
  logic [3:0]  ocr;
  logic [4:0]  odly;
  int          mismatches, n_tests, seed, m, r, k, c;
  logic [11:0] ra [8] = '{ADDR_LOOP_CTRL, ADDR_STAT_ROUTE, ADDR_MODE_RATE,
    ADDR_INPUT_CFG, ADDR_LOS_CFG, ADDR_CLK_DELAY, ADDR_CLK_INVERT,
    ADDR_WIDTH_SRC};
  logic [15:0] rv [8] = '{RST_LOOP_CTRL, RST_STAT_ROUTE, RST_MODE_RATE,
    RST_INPUT_CFG, RST_LOS_CFG, RST_CLK_DELAY, RST_CLK_INVERT,
    RST_WIDTH_SRC};
  logic [15:0] mw [4] = '{16'h0010, 16'h0010, 16'h0009, 16'h0000};
  srx_output_lock i_dut (.clk_sys, .reset_n, .csr_addr, .csr_wdata,
    .csr_wr, .csr_rdata, .bus_width_select, .power_down, .detected_rate,
    .detected_frac, .pll_locked, .video_valid, .stream_valid, .word_valid,
    .raw_word, .transport_byte, .comma_seen, .disparity_err,
    .illegal_code, .deser_input_sel(dsel), .loop_input_sel(lsel),
    .signal_loss_input_choice(lch), .serial_loop_output_en(len),
    .serial_loop_output_retimed(lret), .line_rate, .status_pins, .dout,
    .dout_strobe(strb), .double_edge_active(dea),
    .output_clock_rate(ocr), .output_clock_frac(ofrac),
    .output_clock_delay(odly), .output_clock_invert(oinv));
  srx_sink i_sink (.clk_sys, .dout, .dout_strobe(strb), .last_word);
  function automatic logic [2:0] lr(input logic [1:0] b);
    return b[0] ? SRX_RATE_SD : (b[1] ? SRX_RATE_3G : SRX_RATE_HD);
  endfunction : lr
  function automatic logic [3:0] ck(input logic w, d, logic [2:0] e);
    if (e == SRX_RATE_3G) return SRX_CLK_148M5;
    if (e == SRX_RATE_HD) return (w | d) ? SRX_CLK_74M25 : SRX_CLK_148M5;
    return (w | d) ? SRX_CLK_13M5 : SRX_CLK_27M;
  endfunction : ck
  function automatic logic [19:0] mp(input int m);
    if (m == 1) return {raw_word[9:0], 10'h0};
    if (m == 2) return {disparity_err | illegal_code, comma_seen,
      transport_byte, 10'h0};
    return raw_word;
  endfunction : mp
  task automatic chk(input logic [19:0] s, e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    csr_addr <= a;
    csr_wdata <= d;
    csr_wr <= 1'b1;
    @(posedge clk_sys);
    csr_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {csr_wr, bus_width_select, power_down, detected_frac, pll_locked} = 0;
    {video_valid, stream_valid, word_valid, comma_seen} = 0;
    {disparity_err, illegal_code, csr_addr, csr_wdata} = 0;
    {detected_rate, raw_word, transport_byte, reset_n} = 0;
    seed = 32'he5ba;
    wt(2);
    reset_n <= 1'b1;
    wt(1);
    chk(status_pins, 0);
    for (k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      csr_addr <= ra[k];
      #1 chk(csr_rdata, rv[k]);
    end
    for (k = 0; k < 8; k++) begin
      v = $random(seed);
      wr(ADDR_INPUT_CFG, v & 16'h000c);
      wr(ADDR_LOS_CFG, v & 16'h0100);
      chk(dsel, v[2]);
      chk(lsel, v[3]);
      chk(lch, v[8]);
    end
    for (k = 0; k < 8; k++) begin
      wr(ADDR_INPUT_CFG, k[2] ? 16'h000c : 16'h0008);
      wr(ADDR_LOOP_CTRL, k[1:0]);
      chk(len, k[1]);
      chk(lret, k[2] & k[1] & ~k[0]);
    end
    for (k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      {detected_frac, detected_rate} <= k[2:0];
      wr(ADDR_MODE_RATE, k[2] ? 16'h0014 : (16'h0010 | k[1:0]));
      chk(line_rate, lr(k[1:0]));
      chk(ofrac, k[2] & ~k[0]);
    end
    dly = $random(seed);
    inv = $random(seed);
    wr(ADDR_CLK_DELAY, dly);
    wr(ADDR_CLK_INVERT, inv);
    for (r = 0; r < 3; r++) begin
      for (k = 0; k < 3; k++) begin
        wr(ADDR_MODE_RATE, 16'h0010 | r[1:0]);
        wr(ADDR_WIDTH_SRC, {13'h0, k == 2, k == 0, 1'b1});
        wt(3);
        chk(ocr, ck(k == 0, k == 2, lr(r[1:0])));
        chk(dea, k == 2 || (k == 1 && r == 2));
        chk(odly, dly[(r == 1 ? 10 : (r == 0 ? 5 : 0)) +: 5]);
        chk(oinv, inv[r == 1 ? 2 : (r == 0 ? 1 : 0)]);
      end
    end
    for (m = 0; m < 3; m++) begin
      for (c = 0; c < 8; c++) begin
        @(posedge clk_sys);
        {stream_valid, video_valid, pll_locked} <= c[2:0];
        wr(ADDR_MODE_RATE, mw[m + 1]);
        wt(3);
        ex = c[0] & (m == 2 | (m == 0 ? c[1] : c[2]));
        chk(status_pins[3], ex);
      end
    end
    for (k = 0; k < 8; k++) begin
      wr(ADDR_STAT_ROUTE, k);
      wt(3);
      chk(status_pins, 6'h1 << (k < 6 ? k : 5));
    end
    wr(ADDR_STAT_ROUTE, 16'h0003);
    wr(ADDR_LOOP_CTRL, 16'h0002);
    power_down <= 1'b1;
    wt(4);
    pll_locked <= 1'b0;
    wt(4);
    chk(status_pins[3], 1);
    csr_addr <= ADDR_LOCK_STATUS;
    #1 chk(csr_rdata, {9'h000, SRX_RATE_HD, 4'he});
    power_down <= 1'b0;
    wt(6);
    chk(status_pins[3], 0);
    for (m = 0; m < 4; m++) begin
      wr(ADDR_MODE_RATE, mw[m]);
      wr(ADDR_WIDTH_SRC, 16'h0000);
      bus_width_select <= (m == 0 || m == 3);
      wt(4);
      for (k = 0; k < 24; k++) begin
        @(posedge clk_sys);
        word_valid <= k < 23;
        raw_word <= $random(seed);
        {comma_seen, disparity_err, illegal_code} <= $random(seed);
        transport_byte <= $random(seed);
        #1;
        if (k > 0) chk(dout, ex);
        if (k > 0) chk(dout[19:18], ex[19:18]);
        if (k > 0) chk(strb, 1);
        ep = ex;
        ex = mp(m);
      end
      wt(1);
      chk(last_word, ep);
    end
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
